// File: lolu_unit.sv
// long constant-offset load unit: decode, address, memory request, write-back
// assumes issue inputs and memory data come from logic on sys_clk, and that
// memory returns the addressed word two cycles after mem_req_q
//
// Summary of operation
// RULE1: base is B14 when bit clear, B15 otherwise
// RULE2: offset is 15-bit unsigned instruction constant
// RULE3: only the second data unit accepts it
// RULE4: offset shifted 0, 1, 2 per size
// RULE5: base plus/minus offset is address; base untouched
// RULE6: always linear addressing, mode setting ignored
// RULE7: half/byte data land in low bits
// RULE8: signed loads sign-extend the upper bits
// RULE9: unsigned loads zero-fill the upper bits
// RULE10: word loads fill all 32 bits
// RULE11: side bit picks A or B file
// RULE12: type field decodes five load kinds
// RULE13: false predicate means no access, no write
// RULE14: result visible after four delay slots
`timescale 1ns/1ps
module lolu_unit (
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst_b,
	// apb slave
	input  wire lolu_pkg::lolu_apb_req_type apb_req,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// issue from the pipeline and the two pointer registers
	input  wire lolu_pkg::lolu_issue_type iss,
	input  wire logic [31:0]              base_b14,
	input  wire logic [31:0]              base_b15,
	// data memory port
	output logic                          mem_req,
	output logic      [31:0]              mem_addr,
	input  wire logic [31:0]              mem_rdata,
	// register file write-back
	output lolu_pkg::lolu_wb_type         wb
);
	import lolu_pkg::*;

	// ==================================================================
	// state
	typedef struct packed {
		logic [31:0]                       prdata;
		logic                              pready;
		logic                              pslverr;
		logic                              ctrl_en;
		logic                              ctrl_sub;
		logic [15:0]                       addr_mode;
		logic [15:0]                       load_cnt;
		logic [15:0]                       refuse_cnt;
		lolu_stage_type [STAGES-1:0]       stg;
		logic                              mem_req;
		logic [31:0]                       mem_addr;
		lolu_wb_type                       wb;
	} lolu_state_type;

	lolu_state_type st_q;
	lolu_state_type st_d;

	// ==================================================================
	// decode
	logic        is_long_ld;
	logic        accept;
	logic        refuse;
	logic [2:0]  ld_type;
	logic [14:0] cst;
	logic [31:0] scaled;
	logic [31:0] base_val;
	logic [31:0] eff_addr;
	logic        type_ok;
	logic [31:0] ext_out;
	logic        apb_acc;
	logic        apb_hit;

	assign ld_type = iss.word[FLD_TYPE_HI:FLD_TYPE_LO];
	assign cst     = iss.word[FLD_CST_HI:FLD_CST_LO]; // see RULE2
	assign type_ok = (ld_type == TYPE_SBYTE) || (ld_type == TYPE_UBYTE) ||
	                 (ld_type == TYPE_SHALF) || (ld_type == TYPE_UHALF) ||
	                 (ld_type == TYPE_WORD); // see RULE12
	assign is_long_ld = iss.valid && type_ok &&
	                    (iss.word[FLD_FMT_HI:FLD_FMT_LO] == FMT_LONG_LD);
	// a load offered to any other unit is refused outright
	assign accept = is_long_ld && iss.unit_d2 && iss.pred_true && st_q.ctrl_en; // see RULE3
	assign refuse = is_long_ld && !(iss.unit_d2 && iss.pred_true && st_q.ctrl_en); // see RULE13

	always_comb begin
		case (ld_type) // see RULE4
			TYPE_SHALF, TYPE_UHALF: scaled = {16'h0000, cst, 1'b0};
			TYPE_WORD:              scaled = {15'h0000, cst, 2'b00};
			default:                scaled = {17'h00000, cst};
		endcase
	end

	assign base_val = iss.word[FLD_BASE_SEL] ? base_b15 : base_b14; // see RULE1
	// addr_mode is never consulted here: circular buffers do not apply
	assign eff_addr = st_q.ctrl_sub ? (base_val - scaled) : (base_val + scaled); // see RULE6

	// the word stands on mem_rdata while its load sits in the last stage
	lolu_extend u_extend (
		.ltype    (st_q.stg[2].ltype),
		.lane     (st_q.stg[2].lane),
		.mem_word (mem_rdata),
		.result   (ext_out)
	);

	assign apb_acc = apb_req.psel && apb_req.penable && !st_q.pready;
	assign apb_hit = (apb_req.paddr == REG_CTRL) || (apb_req.paddr == REG_ADDR_MODE) ||
	                 (apb_req.paddr == REG_COUNT) || (apb_req.paddr == REG_LAST_ADDR);

	// ==================================================================
	// next state
	always_comb begin
		st_d = st_q;

		// apb: answer one cycle into the access phase; writes land there too
		st_d.pready  = apb_acc;
		st_d.pslverr = apb_acc && !apb_hit;
		st_d.prdata  = 32'h00000000;
		if (apb_acc && !apb_req.pwrite) begin
			case (apb_req.paddr)
				REG_CTRL:      st_d.prdata = {30'h00000000, st_q.ctrl_sub, st_q.ctrl_en};
				REG_ADDR_MODE: st_d.prdata = {16'h0000, st_q.addr_mode};
				REG_COUNT:     st_d.prdata = {st_q.refuse_cnt, st_q.load_cnt};
				REG_LAST_ADDR: st_d.prdata = st_q.mem_addr;
				default:       st_d.prdata = 32'h00000000;
			endcase
		end
		if (apb_acc && apb_req.pwrite) begin
			case (apb_req.paddr)
				REG_CTRL: begin
					st_d.ctrl_en  = apb_req.pwdata[CTRL_EN_BIT];
					st_d.ctrl_sub = apb_req.pwdata[CTRL_SUB_BIT];
				end
				REG_ADDR_MODE: st_d.addr_mode = apb_req.pwdata[15:0];
				default: ;
			endcase
		end

		// issue stage to memory request
		st_d.mem_req = accept; // see RULE13
		if (accept) begin
			st_d.mem_addr = eff_addr; // see RULE5
			st_d.load_cnt = st_q.load_cnt + 16'h0001;
		end
		if (refuse) begin
			st_d.refuse_cnt = st_q.refuse_cnt + 16'h0001;
		end

		// delay pipeline: stg[0] cycle 1, stg[1] cycle 2, stg[2] cycle 3 (data arrives)
		st_d.stg[0].valid   = accept;
		st_d.stg[0].ltype   = ld_type;
		st_d.stg[0].dst_b   = iss.word[FLD_DST_SIDE];
		st_d.stg[0].dst_reg = iss.word[FLD_DST_HI:FLD_DST_LO];
		st_d.stg[0].lane    = eff_addr[1:0];
		for (int i = 1; i < STAGES; i++) begin
			st_d.stg[i] = st_q.stg[i-1]; // see RULE14
		end

		// extend the word in cycle 3 as it arrives, present write-back in cycle 4;
		// index and data hold between loads
		st_d.wb.wr_a = st_q.stg[2].valid && !st_q.stg[2].dst_b; // see RULE11
		st_d.wb.wr_b = st_q.stg[2].valid && st_q.stg[2].dst_b;  // see RULE11
		if (st_q.stg[2].valid) begin
			st_d.wb.reg_idx = st_q.stg[2].dst_reg;
			st_d.wb.data    = ext_out; // see RULE14
		end
	end

	// ==================================================================
	// registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q           <= '0;
			st_q.ctrl_en   <= CTRL_EN_RST;
			st_q.ctrl_sub  <= CTRL_SUB_RST;
			st_q.addr_mode <= ADDR_MODE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata   = st_q.prdata;
	assign pready   = st_q.pready;
	assign pslverr  = st_q.pslverr;
	assign mem_req  = st_q.mem_req;
	assign mem_addr = st_q.mem_addr;
	assign wb       = st_q.wb;

	// ==================================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	logic [31:0] exp_b14_word;
	logic [31:0] exp_b15_byte;
	logic [31:0] exp_b15_word;
	assign exp_b14_word = base_b14 + {15'h0000, cst, 2'b00};
	assign exp_b15_word = base_b15 + {15'h0000, cst, 2'b00};
	assign exp_b15_byte = base_b15 + {17'h00000, cst};

	a_unit_gate_off: assert property ( // see RULE3
		(is_long_ld && !iss.unit_d2) |=> !mem_req)
		else $error("load accepted on wrong unit");

	a_pred_false_nop: assert property ( // see RULE13
		(is_long_ld && !iss.pred_true) |=> !mem_req ##3 !(wb.wr_a || wb.wr_b))
		else $error("false predicate still loaded");

	a_word_addr_b14: assert property ( // see RULE1
		(accept && !iss.word[FLD_BASE_SEL] && ld_type == TYPE_WORD && !st_q.ctrl_sub)
		|=> mem_req && mem_addr == $past(exp_b14_word))
		else $error("word address from B14 wrong");

	a_byte_addr_b15: assert property ( // see RULE4
		(accept && iss.word[FLD_BASE_SEL] && ld_type == TYPE_SBYTE && !st_q.ctrl_sub)
		|=> mem_addr == $past(exp_b15_byte))
		else $error("byte address from B15 wrong");

	a_mode_ignored: assert property ( // see RULE6
		(accept && st_q.addr_mode != 16'h0000 && ld_type == TYPE_WORD && !st_q.ctrl_sub)
		|=> mem_addr == $past(iss.word[FLD_BASE_SEL] ? exp_b15_word : exp_b14_word))
		else $error("addressing mode changed address");

	a_wb_four_slots: assert property ( // see RULE14
		mem_req |-> ##3 (wb.wr_a || wb.wr_b))
		else $error("write-back not at fourth slot");

	a_dst_side_b: assert property ( // see RULE11
		(accept && iss.word[FLD_DST_SIDE]) |-> ##4 wb.wr_b && !wb.wr_a &&
		wb.reg_idx == $past(iss.word[FLD_DST_HI:FLD_DST_LO], 4))
		else $error("wrong destination file");

	a_sbyte_extend: assert property ( // see RULE8
		(accept && ld_type == TYPE_SBYTE) |-> ##4 wb.data[31:8] == {24{wb.data[7]}})
		else $error("signed byte not sign-extended");

	a_uhalf_zero: assert property ( // see RULE9
		(accept && ld_type == TYPE_UHALF) |-> ##4 wb.data[31:16] == 16'h0000)
		else $error("unsigned half not zero-filled");

	a_uhalf_low: assert property ( // see RULE7
		(accept && ld_type == TYPE_UHALF && !eff_addr[1]) |-> ##3 1'b1 ##1
		wb.data[15:0] == $past(mem_rdata[15:0]))
		else $error("half data not in low bits");

	a_word_full: assert property ( // see RULE10
		(accept && ld_type == TYPE_WORD) |-> ##4 wb.data == $past(mem_rdata))
		else $error("word load not full width");

	a_apb_answer: assert property (
		(apb_req.psel && apb_req.penable && !pready) |=> pready ##1 !pready)
		else $error("apb answer not one cycle");

	c_word_load:   cover property (accept && ld_type == TYPE_WORD ##4 wb.wr_b);
	c_sbyte_load:  cover property (accept && ld_type == TYPE_SBYTE ##4 wb.data[31]);
	c_back_to_back: cover property (accept ##1 accept);
	c_refused:     cover property (refuse && !iss.unit_d2);

endmodule : lolu_unit

// File: lolu_pkg.sv
// constants and carrier types for the long-offset load unit
// assumes one core clock and a 32-bit word-wide data memory port
package lolu_pkg;

	// ==================================================================
	// instruction word layout of the long constant-offset load form
	localparam int unsigned FLD_DST_HI   = 27;
	localparam int unsigned FLD_DST_LO   = 23;
	localparam int unsigned FLD_CST_HI   = 22;
	localparam int unsigned FLD_CST_LO   = 8;
	localparam int unsigned FLD_BASE_SEL = 7;
	localparam int unsigned FLD_TYPE_HI  = 6;
	localparam int unsigned FLD_TYPE_LO  = 4;
	localparam int unsigned FLD_FMT_HI   = 3;
	localparam int unsigned FLD_FMT_LO   = 2;
	localparam int unsigned FLD_DST_SIDE = 1;
	localparam logic [1:0]  FMT_LONG_LD  = 2'h3;
	localparam int unsigned CST_WIDTH    = 15;

	// ==================================================================
	// access type field encodings
	localparam logic [2:0] TYPE_SBYTE = 3'h2;
	localparam logic [2:0] TYPE_UBYTE = 3'h1;
	localparam logic [2:0] TYPE_SHALF = 3'h4;
	localparam logic [2:0] TYPE_UHALF = 3'h0;
	localparam logic [2:0] TYPE_WORD  = 3'h6;

	// ==================================================================
	// timing: issue in cycle 0, memory request cycle 1, data cycle 3,
	// write-back strobe cycle 4, readable by cycle 5 (four delay slots)
	localparam int unsigned DELAY_SLOTS  = 4;
	localparam int unsigned STAGES       = 3;

	// ==================================================================
	// apb register map (byte addresses) and reset values
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_ADDR_MODE = 8'h04;
	localparam logic [7:0]  REG_COUNT     = 8'h08;
	localparam logic [7:0]  REG_LAST_ADDR = 8'h0c;
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_SUB_BIT  = 1;
	localparam logic        CTRL_EN_RST   = 1'b1;
	localparam logic        CTRL_SUB_RST  = 1'b0;
	localparam logic [15:0] ADDR_MODE_RST = 16'h0000;

	// ==================================================================
	// carriers
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} lolu_apb_req_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] word;
		logic        unit_d2;
		logic        pred_true;
	} lolu_issue_type;

	typedef struct packed {
		logic        valid;
		logic [2:0]  ltype;
		logic        dst_b;
		logic [4:0]  dst_reg;
		logic [1:0]  lane;
	} lolu_stage_type;

	typedef struct packed {
		logic        wr_a;
		logic        wr_b;
		logic [4:0]  reg_idx;
		logic [31:0] data;
	} lolu_wb_type;

endpackage : lolu_pkg

// File: lolu_extend.sv
// lane select and sign or zero extension of loaded memory data
// assumes a little-endian 32-bit memory word and a pure combinational use
`timescale 1ns/1ps
module lolu_extend (
	// load description
	input  wire logic [2:0]  ltype,
	input  wire logic [1:0]  lane,
	// memory word and result
	input  wire logic [31:0] mem_word,
	output logic      [31:0] result
);
	import lolu_pkg::*;

	logic [7:0]  byte_val;
	logic [15:0] half_val;

	always_comb begin
		byte_val = mem_word[8*lane +: 8];
		half_val = lane[1] ? mem_word[31:16] : mem_word[15:0];
		case (ltype) // see RULE12
			TYPE_SBYTE: result = {{24{byte_val[7]}}, byte_val};  // see RULE8
			TYPE_UBYTE: result = {24'h000000, byte_val};         // see RULE9
			TYPE_SHALF: result = {{16{half_val[15]}}, half_val}; // see RULE8
			TYPE_UHALF: result = {16'h0000, half_val};           // see RULE7
			TYPE_WORD:  result = mem_word;                       // see RULE10
			default:    result = 32'h00000000;
		endcase
	end

endmodule : lolu_extend

// File: lolu_mem_model.sv
// data memory model for the long-offset load unit
// assumes mem_req is a one-cycle pulse on sys_clk; answers two cycles later
`timescale 1ns/1ps
module lolu_mem_model (
	// clock
	input  wire logic        sys_clk,
	// request, word to return, answer
	input  wire logic        mem_req,
	input  wire logic [31:0] fill,
	output logic      [31:0] mem_rdata
);
	logic [1:0] req_q = 2'h0;
	always_ff @(posedge sys_clk) begin
		req_q <= {req_q[0], mem_req};
	end
	// outside the answer cycle show a wrong, changing word so stale data cannot pass
	assign mem_rdata = req_q[1] ? fill : ~fill ^ {30'h0, req_q};
endmodule : lolu_mem_model

// File: long_offset_load_unit_test.sv
// testbench for the long-offset load unit: apb register access and load issue
// assumes a 2-cycle memory latency model and one-wait-state apb answers
`timescale 1ns/1ps
module long_offset_load_unit_test;
	import lolu_pkg::*;
	logic             sys_clk  = 1'b0;
	logic             rst_b    = 1'b0;
	lolu_apb_req_type apb_req  = '0;
	lolu_issue_type   iss      = '0;
	logic [31:0]      base_b14 = 32'h1000_0101;
	logic [31:0]      base_b15 = 32'h2000_0ffe;
	logic [31:0]      fill     = 32'h0;
	logic [31:0]      prdata, mem_addr, mem_rdata, last_a;
	logic             pready, pslverr, mem_req;
	logic             sub      = 1'b0;
	lolu_wb_type      wb;
	int               n_errors = 0;
	int               num_checks = 0;
	int               n_acc = 0;
	int               n_ref = 0;
	logic [2:0]       types [5] = '{TYPE_SBYTE, TYPE_UBYTE, TYPE_SHALF, TYPE_UHALF, TYPE_WORD};

	always #2 sys_clk = ~sys_clk;

	lolu_unit u_lolu_unit (.sys_clk(sys_clk), .rst_b(rst_b), .apb_req(apb_req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .iss(iss), .base_b14(base_b14), .base_b15(base_b15),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .wb(wb));
	lolu_mem_model u_lolu_mem_model (.sys_clk(sys_clk), .mem_req(mem_req), .fill(fill),
		.mem_rdata(mem_rdata));

	// ==================================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, input logic [31:0] exp);
		@(posedge sys_clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		// only the watchdog ends a wait that never gets its answer
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		chk({31'h0, pslverr}, {31'h0, addr > REG_LAST_ADDR}, "slave error");
		if (!wr) chk(prdata, exp, "read data");
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		if (wr && addr == REG_CTRL) sub = wd[CTRL_SUB_BIT];
	endtask : apb

	// issue one long load; take says whether it must reach memory
	task automatic load(input logic [2:0] ty, input logic [14:0] off, input logic sel, input logic side,
		input logic unit, input logic pred, input logic [31:0] f, input logic take);
		logic [31:0] a, e;
		int sh;
		sh = (ty == TYPE_WORD) ? 2 : (ty == TYPE_SHALF || ty == TYPE_UHALF) ? 1 : 0;
		a = sel ? base_b15 : base_b14;
		a = sub ? a - ({17'h0, off} << sh) : a + ({17'h0, off} << sh);
		case (ty)
			TYPE_SBYTE: e = {{24{f[8*a[1:0]+7]}}, f[8*a[1:0]+:8]};
			TYPE_UBYTE: e = {24'h0, f[8*a[1:0]+:8]};
			TYPE_SHALF: e = {{16{f[16*a[1]+15]}}, f[16*a[1]+:16]};
			TYPE_UHALF: e = {16'h0, f[16*a[1]+:16]};
			default:    e = f;
		endcase
		@(posedge sys_clk);
		fill <= f;
		iss <= '{valid: 1'b1, word: {4'h0, off[4:0], off, sel, ty, FMT_LONG_LD, side, 1'b0},
			unit_d2: unit, pred_true: pred};
		@(posedge sys_clk);
		iss.valid <= 1'b0;
		@(posedge sys_clk);
		chk({31'h0, mem_req}, {31'h0, take}, "request");
		if (take) chk(mem_addr, a, "address");
		repeat (3) @(posedge sys_clk);
		chk({30'h0, wb.wr_b, wb.wr_a}, take ? {30'h0, side, !side} : 32'h0, "strobe");
		if (take) chk(wb.data, e, "data");
		if (take) chk({27'h0, wb.reg_idx}, {27'h0, off[4:0]}, "index");
		if (take) last_a = a;
		if (ty !== 3'h3) begin
			if (take) n_acc++;
			else n_ref++;
		end
	endtask : load

	task automatic results();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results

	// ==================================================================
	// tests
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		apb(1'b0, REG_CTRL, 32'h0, 32'h1);
		apb(1'b0, REG_ADDR_MODE, 32'h0, 32'h0);
		apb(1'b0, REG_COUNT, 32'h0, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 5; i++) begin
			load(types[i], 15'h7ffd - 15'(i), 1'b0, 1'b0, 1'b1, 1'b1, 32'h8f7e_81f2, 1'b1);
			load(types[i], 15'h4003 + 15'(i), 1'b1, 1'b1, 1'b1, 1'b1, 32'h70ff_8e01, 1'b1);
		end
		$display("test load kinds done");
		apb(1'b1, REG_ADDR_MODE, 32'hffff_ffff, 32'h0);
		apb(1'b0, REG_ADDR_MODE, 32'h0, 32'h0000_ffff);
		load(TYPE_WORD, 15'h1234, 1'b1, 1'b0, 1'b1, 1'b1, 32'hc3a5_5a3c, 1'b1);
		apb(1'b1, REG_CTRL, 32'h3, 32'h0);
		load(TYPE_SHALF, 15'h5555, 1'b1, 1'b0, 1'b1, 1'b1, 32'h9001_7ffe, 1'b1);
		$display("test linear and subtract done");
		apb(1'b1, REG_CTRL, 32'h0, 32'h0);
		load(TYPE_WORD, 15'h0010, 1'b0, 1'b1, 1'b1, 1'b1, 32'h1111_2222, 1'b0);
		apb(1'b1, REG_CTRL, 32'h1, 32'h0);
		load(TYPE_WORD, 15'h0020, 1'b0, 1'b1, 1'b0, 1'b1, 32'h3333_4444, 1'b0);
		load(TYPE_UBYTE, 15'h0030, 1'b1, 1'b0, 1'b1, 1'b0, 32'h5555_6666, 1'b0);
		load(3'h3, 15'h0040, 1'b0, 1'b0, 1'b1, 1'b1, 32'h7777_8888, 1'b0);
		$display("test refusals done");
		apb(1'b1, REG_COUNT, 32'hffff_ffff, 32'h0);
		apb(1'b0, REG_COUNT, 32'h0, {n_ref[15:0], n_acc[15:0]});
		apb(1'b0, REG_LAST_ADDR, 32'h0, last_a);
		apb(1'b0, 8'h10, 32'h0, 32'h0);
		$display("test status registers done");
		results();
	end

	// cut a hang short
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_errors++;
		results();
	end
endmodule : long_offset_load_unit_test
